// >>> irq_source_resolver.v
// Priority resolution of pending interrupts into a source code
`timescale 1ns/1ps
`default_nettype none
`include "msg_status_map.vh"

module irq_source_resolver #(
	parameter N = 32
) (
	input  wire         status_pending_i,
	input  wire [N-1:0] object_pending_i,
	output reg  [15:0]  code_o
);

	integer i;

	always @* begin
		code_o = `CODE_NONE;
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (object_pending_i[i]) begin
				code_o = i[15:0] + 16'h0001;
			end
		end
		if (status_pending_i) begin
			code_o = `CODE_STATUS;
		end
	end

endmodule

`default_nettype wire

// >>> msg_handler_status.v
// Message handler status vectors, interrupt source code and register slave
//
// What this block does
// - Status registers are read-only except event status, where writing one clears a bit.
// - Source code shows highest-priority pending source, not arrival order.
// - Pending source stays pending and visible until software clears it.
// - Interrupt request asserts when source code nonzero and global enable set.
// - Request holds until code returns to zero or enable clears.
// - Status interrupt outranks all objects, code 0x8000.
// - Among objects, lowest number wins.
// - Reading status register clears the status interrupt.
// - Code is zero, object number 1-32, or 0x8000 only.
// - Transmit-pending flags readable packed, objects 1-16 low, 17-32 high.
// - Transmit-pending changes by software, remote frame, or transmit success.
// - Fresh-data flags readable as packed vector, one per object.
// - Fresh-data changes by software, data frame received, or transmit success.
// - Object irq flags readable packed; changes reach source code at once.
// - Object irq flag changes by software or handler after frame done.
// - Valid flags readable, software-only; invalid objects ignored by handler.
// - Handler sets irq flag only if receive or transmit enable set.
`timescale 1ns/1ps
`default_nettype none
`include "msg_status_map.vh"

module msg_handler_status #(
	parameter N = 32
) (
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [11:0] adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// Object access window
	input  wire        acc_write_i,
	input  wire [5:0]  acc_obj_i,
	input  wire        acc_tx_pending_we_i,
	input  wire        acc_tx_pending_i,
	input  wire        acc_fresh_data_we_i,
	input  wire        acc_fresh_data_i,
	input  wire        acc_irq_we_i,
	input  wire        acc_irq_i,
	input  wire        acc_valid_we_i,
	input  wire        acc_valid_i,
	// Handler events
	input  wire        rx_frame_i,
	input  wire        rx_remote_i,
	input  wire [5:0]  rx_obj_i,
	input  wire        rx_irq_enable_i,
	input  wire        remote_enable_i,
	input  wire        tx_done_i,
	input  wire [5:0]  tx_obj_i,
	input  wire        tx_irq_enable_i,
	input  wire        status_event_i,
	// Status to handler and interrupt controller
	output wire [31:0] tx_pending_o,
	output wire [31:0] object_valid_o,
	output wire [15:0] irq_source_code_o,
	output wire        irq_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Object number 1..N to one-hot, zero for out-of-range numbers
	function [N-1:0] obj_onehot;
		input [5:0] num;
		integer k;
		begin
			obj_onehot = {N{1'b0}};
			for (k = 0; k < N; k = k + 1) begin
				if (num == k[5:0] + 6'd1) begin
					obj_onehot[k] = 1'b1;
				end
			end
		end
	endfunction

	// Sixteen-object half of a vector, zero above
	function [31:0] half_word;
		input [N-1:0] vec;
		input         upper;
		begin
			half_word = upper ? {16'h0000, vec[31:16]} : {16'h0000, vec[15:0]};
		end
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	wire [N-1:0]  tx_pending_vector;
	wire [N-1:0]  fresh_data_vector;
	wire [N-1:0]  object_irq_vector;
	wire [N-1:0]  object_valid_vector;
	wire [N-1:0]  acc_hot;
	wire [N-1:0]  rx_hot;
	wire [N-1:0]  tx_hot;
	wire [N-1:0]  rx_live;
	wire [N-1:0]  tx_live;
	wire [15:0]   irq_source_code;
	wire          bus_req;
	wire          bus_take;
	wire          bus_wr;
	wire          bus_rd;
	reg  [N-1:0]  tx_set;
	reg  [N-1:0]  tx_clr;
	reg  [N-1:0]  fresh_set;
	reg  [N-1:0]  fresh_clr;
	reg  [N-1:0]  irq_set;
	reg  [N-1:0]  irq_clr;
	reg  [N-1:0]  valid_set;
	reg  [N-1:0]  valid_clr;
	reg  [31:0]   control_reg;
	reg           status_irq_reg;
	reg           status_irq_next;
	reg  [`EVT_WIDTH-1:0] event_reg;
	reg  [`EVT_WIDTH-1:0] event_next;
	reg  [`EVT_WIDTH-1:0] event_hit;
	reg  [`EVT_WIDTH-1:0] mask_reg;
	reg  [31:0]   read_data;
	wire          gie;

	// ----------------------------------------------------------------
	// Event decode
	// ----------------------------------------------------------------
	assign acc_hot = acc_write_i ? obj_onehot(acc_obj_i) : {N{1'b0}};
	assign rx_hot  = rx_frame_i ? obj_onehot(rx_obj_i) : {N{1'b0}};
	assign tx_hot  = tx_done_i ? obj_onehot(tx_obj_i) : {N{1'b0}};
	assign rx_live = rx_hot & object_valid_vector;
	assign tx_live = tx_hot & object_valid_vector;

	// ----------------------------------------------------------------
	// Flag set and clear masks
	// ----------------------------------------------------------------
	always @* begin
		tx_set = (acc_tx_pending_we_i && acc_tx_pending_i) ? acc_hot : {N{1'b0}};
		tx_clr = (acc_tx_pending_we_i && !acc_tx_pending_i) ? acc_hot : {N{1'b0}};
		if (rx_remote_i && remote_enable_i) begin
			tx_set = tx_set | rx_live;
		end
		tx_clr = tx_clr | tx_live;
		fresh_set = (acc_fresh_data_we_i && acc_fresh_data_i) ? acc_hot : {N{1'b0}};
		fresh_clr = (acc_fresh_data_we_i && !acc_fresh_data_i) ? acc_hot : {N{1'b0}};
		if (!rx_remote_i) begin
			fresh_set = fresh_set | rx_live;
		end
		fresh_clr = fresh_clr | tx_live;
		irq_set = (acc_irq_we_i && acc_irq_i) ? acc_hot : {N{1'b0}};
		irq_clr = (acc_irq_we_i && !acc_irq_i) ? acc_hot : {N{1'b0}};
		if (rx_irq_enable_i) begin
			irq_set = irq_set | rx_live;
		end
		if (tx_irq_enable_i) begin
			irq_set = irq_set | tx_live;
		end
		valid_set = (acc_valid_we_i && acc_valid_i) ? acc_hot : {N{1'b0}};
		valid_clr = (acc_valid_we_i && !acc_valid_i) ? acc_hot : {N{1'b0}};
	end

	// ----------------------------------------------------------------
	// Flag vectors
	// ----------------------------------------------------------------
	object_flag_bank #(.N(N)) tx_pending_bank (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (tx_set),
		.clr_i   (tx_clr),
		.flags_o (tx_pending_vector)
	);

	object_flag_bank #(.N(N)) fresh_data_bank (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (fresh_set),
		.clr_i   (fresh_clr),
		.flags_o (fresh_data_vector)
	);

	object_flag_bank #(.N(N)) object_irq_bank (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (irq_set),
		.clr_i   (irq_clr),
		.flags_o (object_irq_vector)
	);

	object_flag_bank #(.N(N)) object_valid_bank (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (valid_set),
		.clr_i   (valid_clr),
		.flags_o (object_valid_vector)
	);

	assign tx_pending_o   = tx_pending_vector;
	assign object_valid_o = object_valid_vector;

	// ----------------------------------------------------------------
	// Interrupt source code
	// ----------------------------------------------------------------
	// code follows flags combinationally
	irq_source_resolver #(.N(N)) resolver (
		.status_pending_i (status_irq_reg),
		.object_pending_i (object_irq_vector),
		.code_o           (irq_source_code)
	);

	assign irq_source_code_o = irq_source_code;

	// ----------------------------------------------------------------
	// Wishbone handshake
	// ----------------------------------------------------------------
	assign bus_req  = cyc_i && stb_i;
	assign bus_take = bus_req && !ack_o;
	assign bus_wr   = bus_take && we_i;
	assign bus_rd   = bus_take && !we_i;
	assign gie      = control_reg[`CTRL_GIE_BIT];

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= bus_take;
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// reads show live flags
	always @* begin
		case (adr_i & 12'hffc)
			`OFS_CONTROL:         read_data = control_reg;
			`OFS_STATUS:          read_data = {31'h00000000, status_irq_reg};
			`OFS_IRQ_SOURCE_CODE: read_data = {16'h0000, irq_source_code};
			`OFS_TX_PENDING_LO:   read_data = half_word(tx_pending_vector, 1'b0);
			`OFS_TX_PENDING_HI:   read_data = half_word(tx_pending_vector, 1'b1);
			`OFS_FRESH_DATA_LO:   read_data = half_word(fresh_data_vector, 1'b0);
			`OFS_FRESH_DATA_HI:   read_data = half_word(fresh_data_vector, 1'b1);
			`OFS_OBJECT_IRQ_LO:   read_data = half_word(object_irq_vector, 1'b0);
			`OFS_OBJECT_IRQ_HI:   read_data = half_word(object_irq_vector, 1'b1);
			`OFS_OBJECT_VALID_LO: read_data = half_word(object_valid_vector, 1'b0);
			`OFS_OBJECT_VALID_HI: read_data = half_word(object_valid_vector, 1'b1);
			`OFS_EVENT_STATUS:    read_data = {28'h0000000, event_reg};
			`OFS_EVENT_MASK:      read_data = {28'h0000000, mask_reg};
			default:              read_data = 32'h00000000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else if (bus_rd) begin
			dat_o <= read_data;
		end
	end

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	// control and mask written here; event status write-one-clear below
	always @(posedge clk_i) begin
		if (rst_i) begin
			control_reg <= `RST_CONTROL;
			mask_reg    <= `RST_EVENT;
		end else if (bus_wr && sel_i[0]) begin
			if ((adr_i & 12'hffc) == `OFS_CONTROL) begin
				control_reg <= {24'h000000, dat_i[7:0]};
			end
			if ((adr_i & 12'hffc) == `OFS_EVENT_MASK) begin
				mask_reg <= dat_i[`EVT_WIDTH-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Status interrupt
	// ----------------------------------------------------------------
	always @* begin
		status_irq_next = status_irq_reg;
		if (bus_rd && ((adr_i & 12'hffc) == `OFS_STATUS)) begin
			status_irq_next = 1'b0;
		end
		if (status_event_i) begin
			status_irq_next = 1'b1;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			status_irq_reg <= 1'b0;
		end else begin
			status_irq_reg <= status_irq_next;
		end
	end

	// ----------------------------------------------------------------
	// Sticky event status
	// ----------------------------------------------------------------
	always @* begin
		event_hit = {`EVT_WIDTH{1'b0}};
		event_hit[`EVT_RX_DONE_BIT] = |rx_live && !rx_remote_i;
		event_hit[`EVT_TX_DONE_BIT] = |tx_live;
		event_hit[`EVT_REMOTE_BIT]  = |rx_live && rx_remote_i;
		event_hit[`EVT_STATUS_BIT]  = status_event_i;
		event_next = event_reg;
		if (bus_wr && sel_i[0] && ((adr_i & 12'hffc) == `OFS_EVENT_STATUS)) begin
			event_next = event_next & ~dat_i[`EVT_WIDTH-1:0];
		end
		event_next = event_next | event_hit;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			event_reg <= `RST_EVENT;
		end else begin
			event_reg <= event_next;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	// request while code nonzero and global enable set, or while a masked event is set
	assign irq_o = ((irq_source_code != `CODE_NONE) && gie) || (|(event_reg & mask_reg));

endmodule

`default_nettype wire

// >>> msg_handler_status_assertions.sv
// Port checks for the message handler status block
`timescale 1ns/1ps
`default_nettype none

module handler_checker #(
	parameter N = 32
) (
	input wire logic		clk_i,
	input wire logic		rst_i,
	input wire logic		cyc_i,
	input wire logic		stb_i,
	input wire logic		we_i,
	input wire logic	[11:0]	adr_i,
	input wire logic	[3:0]	sel_i,
	input wire logic	[31:0]	dat_i,
	input wire logic		ack_o,
	input wire logic		acc_write_i,
	input wire logic		acc_valid_we_i,
	input wire logic		rx_frame_i,
	input wire logic	[5:0]	rx_obj_i,
	input wire logic		rx_irq_enable_i,
	input wire logic		tx_done_i,
	input wire logic		status_event_i,
	input wire logic	[31:0]	tx_pending_o,
	input wire logic	[N-1:0]	object_valid_o,
	input wire logic	[15:0]	irq_source_code_o,
	input wire logic		irq_o
);
	logic	gie_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ----------
	// Global enable as last written
	// ----------
	always_ff @(posedge clk_i) begin
		if (rst_i)
			gie_q <= 1'b0;
		else if (cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i[11:2] == 10'h0)
			gie_q <= dat_i[1];
	end

	a_ack_answer: assert property (
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
		else $error("bus answer not a single pulse");
	a_code_range: assert property (
		irq_source_code_o inside {16'h0000, [16'h0001:16'h0020], 16'h8000})
		else $error("source code outside legal set");
	a_irq_assert: assert property (
		(irq_source_code_o != 16'h0 && gie_q) |-> irq_o)
		else $error("request missing while code pending");
	a_irq_release: assert property (
		$fell(irq_o) |-> (irq_source_code_o == 16'h0 || !gie_q))
		else $error("request dropped too early");
	a_valid_cause: assert property (
		!$stable(object_valid_o) |-> $past(acc_write_i && acc_valid_we_i))
		else $error("valid flags changed without software");
	a_txp_cause: assert property (
		!$stable(tx_pending_o) |-> $past(acc_write_i || rx_frame_i || tx_done_i))
		else $error("transmit pending changed without cause");
	a_code_hold: assert property (
		(irq_source_code_o != 16'h0 && !(cyc_i && stb_i) && !acc_write_i && !rx_frame_i
		&& !tx_done_i && !status_event_i) |=> $stable(irq_source_code_o))
		else $error("pending code changed by itself");
	a_rx_code: assert property (
		(irq_source_code_o == 16'h0 && rx_frame_i && rx_irq_enable_i && rx_obj_i >= 6'd1
		&& rx_obj_i <= 6'd32 && object_valid_o[rx_obj_i - 6'd1] && !acc_write_i
		&& !tx_done_i && !status_event_i) |=> irq_source_code_o == {10'h0, $past(rx_obj_i)})
		else $error("reception did not raise its code");
endmodule

`default_nettype wire

// >>> msg_handler_status_tb_top.sv
// Self-checking bench for the message handler status block
`timescale 1ns/1ps
`default_nettype none

module msg_handler_status_tb_top;
	logic	clk_i, rst_i, acc_write_i, acc_tx_pending_we_i, acc_tx_pending_i, acc_fresh_data_we_i;
	logic	acc_fresh_data_i, acc_irq_we_i, acc_irq_i, acc_valid_we_i, acc_valid_i, rx_frame_i;
	logic	rx_remote_i, rx_irq_enable_i, remote_enable_i, tx_done_i, tx_irq_enable_i, status_event_i;
	logic	[5:0]	acc_obj_i, rx_obj_i, tx_obj_i;
	wire logic	cyc_i, stb_i, we_i, ack_o, irq_o;
	wire logic	[11:0]	adr_i;
	wire logic	[3:0]	sel_i;
	wire logic	[31:0]	dat_i, dat_o, tx_pending_o, object_valid_o;
	wire logic	[15:0]	irq_source_code_o;
	logic	[31:0]	txp, frs, irq, vld, seed, exp_v, q[$];
	logic	st, gie;
	int	bad_count = 0;
	int	tests_run = 0;
	logic	[11:0]	ro_ofs[9] = '{12'h10, 12'h100, 12'h104, 12'h120, 12'h124, 12'h140, 12'h144,
		12'h160, 12'h164};

	msg_handler_status #(.N(32)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .acc_write_i, .acc_obj_i, .acc_tx_pending_we_i, .acc_tx_pending_i,
		.acc_fresh_data_we_i, .acc_fresh_data_i, .acc_irq_we_i, .acc_irq_i, .acc_valid_we_i,
		.acc_valid_i, .rx_frame_i, .rx_remote_i, .rx_obj_i, .rx_irq_enable_i, .remote_enable_i,
		.tx_done_i, .tx_obj_i, .tx_irq_enable_i, .status_event_i, .tx_pending_o, .object_valid_o,
		.irq_source_code_o, .irq_o);
	wb_cpu_model i_cpu (.clk_i, .ack_i(ack_o), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
		.adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));

	// ----------
	// Compare, report, finish
	// ----------
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		tests_run++;
		if (seen !== want) begin
			bad_count++;
			$display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic conclude;
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	function automatic logic [15:0] code_exp();
		if (st)
			return 16'h8000;
		for (int j = 0; j < 32; j++)
			if (irq[j])
				return 16'(j + 1);
		return 16'h0;
	endfunction

	// ----------
	// Bus and event drivers
	// ----------
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		i_cpu.xfer(1'b0, a, ~e);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_cpu.xfer(1'b1, a, d);
	endtask

	task automatic chk_ports;
		#1;
		check({16'h0, irq_source_code_o}, {16'h0, code_exp()}, "code");
		check({31'h0, irq_o}, {31'h0, gie && code_exp() != 16'h0}, "irq");
		check(tx_pending_o, txp, "tx pending");
		check(object_valid_o, vld, "valid");
	endtask

	task automatic rd_vecs;
		rd(12'h010, {16'h0, code_exp()});
		rd(12'h100, {16'h0, txp[15:0]});
		rd(12'h104, {16'h0, txp[31:16]});
		rd(12'h120, {16'h0, frs[15:0]});
		rd(12'h124, {16'h0, frs[31:16]});
		rd(12'h140, {16'h0, irq[15:0]});
		rd(12'h144, {16'h0, irq[31:16]});
		rd(12'h160, {16'h0, vld[15:0]});
		rd(12'h164, {16'h0, vld[31:16]});
	endtask

	// Kinds: rx data, rx remote, tx done, four window writes, status event
	task automatic ev(input int k, input logic [5:0] o, input logic [3:0] f);
		int i;
		@(posedge clk_i);
		{rx_obj_i, tx_obj_i, acc_obj_i} <= {3{o}};
		{rx_irq_enable_i, tx_irq_enable_i, remote_enable_i} <= {f[0], f[0], f[1]};
		{acc_tx_pending_i, acc_fresh_data_i, acc_irq_i, acc_valid_i} <= {4{f[0]}};
		{rx_frame_i, rx_remote_i, tx_done_i, status_event_i} <= {k < 2, k == 1, k == 2, k == 7};
		acc_write_i <= k > 2 && k < 7;
		{acc_tx_pending_we_i, acc_fresh_data_we_i, acc_irq_we_i, acc_valid_we_i} <=
			{k == 3, k == 4, k == 5, k == 6};
		@(posedge clk_i);
		{rx_frame_i, tx_done_i, status_event_i, acc_write_i} <= 4'h0;
		i = int'(o) - 1;
		if (i >= 0 && i < 32) begin
			if (k < 3 && vld[i]) begin
				frs[i] = (frs[i] || k == 0) && k != 2;
				txp[i] = (txp[i] || (k == 1 && f[1])) && k != 2;
				irq[i] = irq[i] || f[0];
			end
			case (k)
				3: txp[i] = f[0];
				4: frs[i] = f[0];
				5: irq[i] = f[0];
				6: vld[i] = f[0];
				default: ;
			endcase
		end
		st = st || k == 7;
		chk_ports();
	endtask

	task automatic do_reset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		{txp, frs, irq, vld, st, gie} = 130'h0;
	endtask

	task automatic clear_status;
		rd(12'h004, 32'h1);
		st = 1'b0;
		chk_ports();
	endtask

	// ----------
	// Clock, monitor, watchdog, sequence
	// ----------
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0) begin
			exp_v = (q.size() != 0) ? q.pop_front() : ~dat_o;
			check(dat_o, exp_v, "read data");
		end
	end

	initial begin
		repeat (30000) @(posedge clk_i);
		bad_count++;
		conclude();
	end

	initial begin
		seed = 32'h8b28;
		rst_i = 1'b1;
		{acc_write_i, acc_tx_pending_we_i, acc_tx_pending_i, acc_fresh_data_we_i} = 4'h0;
		{acc_fresh_data_i, acc_irq_we_i, acc_irq_i, acc_valid_we_i, acc_valid_i} = 5'h0;
		{rx_frame_i, rx_remote_i, rx_irq_enable_i, remote_enable_i, tx_done_i} = 5'h0;
		{tx_irq_enable_i, status_event_i, acc_obj_i, rx_obj_i, tx_obj_i} = 20'h0;
		do_reset();
		rd_vecs();
		rd(12'h300, 32'h0);
		ev(0, 6'd4, 4'h1);
		for (int k = 1; k <= 32; k++)
			if (k != 7)
				ev(6, 6'(k), 4'h1);
		wr(12'h000, 32'h2);
		gie = 1'b1;
		ev(0, 6'd20, 4'h1);
		ev(0, 6'd9, 4'h1);
		ev(0, 6'd7, 4'h1);
		ev(7, 6'd0, 4'h0);
		clear_status();
		ev(0, 6'd12, 4'h0);
		ev(1, 6'd30, 4'h2);
		ev(1, 6'd31, 4'h1);
		ev(2, 6'd30, 4'h1);
		ev(2, 6'd12, 4'h0);
		ev(5, 6'd9, 4'h0);
		ev(5, 6'd20, 4'h0);
		ev(5, 6'd30, 4'h0);
		ev(5, 6'd31, 4'h0);
		ev(5, 6'd1, 4'h1);
		wr(12'h000, 32'h0);
		gie = 1'b0;
		chk_ports();
		wr(12'h000, 32'h2);
		gie = 1'b1;
		rd_vecs();
		for (int k = 0; k < 300; k++) begin
			ev($unsigned($random(seed)) % 8, 6'($unsigned($random(seed)) % 34), 4'($random(seed)));
			if (st)
				clear_status();
			if (k % 60 == 0)
				rd_vecs();
		end
		for (int j = 0; j < 9; j++)
			wr(ro_ofs[j], $random(seed));
		rd_vecs();
		wr(12'h000, 32'h0);
		gie = 1'b0;
		wr(12'h200, 32'hf);
		rd(12'h200, 32'h0);
		ev(7, 6'd0, 4'h0);
		rd(12'h200, 32'h8);
		wr(12'h204, 32'h8);
		#1 check({31'h0, irq_o}, 32'h1, "masked event irq");
		wr(12'h200, 32'h8);
		#1 check({31'h0, irq_o}, 32'h0, "event cleared");
		wr(12'h204, 32'h0);
		clear_status();
		do_reset();
		rd_vecs();
		@(posedge clk_i);
		check(q.size(), 32'h0, "reads answered");
		conclude();
	end
endmodule

bind msg_handler_status handler_checker #(.N(N)) i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .sel_i, .dat_i, .ack_o, .acc_write_i, .acc_valid_we_i, .rx_frame_i, .rx_obj_i,
	.rx_irq_enable_i, .tx_done_i, .status_event_i, .tx_pending_o, .object_valid_o,
	.irq_source_code_o, .irq_o);

`default_nettype wire

// >>> msg_status_map.vh
// Offsets, field positions, reset values and codes of the message handler status block
`ifndef MSG_STATUS_MAP_VH
`define MSG_STATUS_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL           12'h000
`define OFS_STATUS            12'h004
`define OFS_IRQ_SOURCE_CODE   12'h010
`define OFS_TX_PENDING_LO     12'h100
`define OFS_TX_PENDING_HI     12'h104
`define OFS_FRESH_DATA_LO     12'h120
`define OFS_FRESH_DATA_HI     12'h124
`define OFS_OBJECT_IRQ_LO     12'h140
`define OFS_OBJECT_IRQ_HI     12'h144
`define OFS_OBJECT_VALID_LO   12'h160
`define OFS_OBJECT_VALID_HI   12'h164
`define OFS_EVENT_STATUS      12'h200
`define OFS_EVENT_MASK        12'h204

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_GIE_BIT          1
`define STAT_IRQ_BIT          0
`define EVT_RX_DONE_BIT       0
`define EVT_TX_DONE_BIT       1
`define EVT_REMOTE_BIT        2
`define EVT_STATUS_BIT        3
`define EVT_WIDTH             4

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RST_CONTROL           32'h00000000
`define RST_VECTOR            32'h00000000
`define RST_EVENT             4'h0
`define CODE_NONE             16'h0000
`define CODE_STATUS           16'h8000

`endif

// >>> object_flag_bank.v
// One packed vector of per-object flags with set and clear masks
`timescale 1ns/1ps
`default_nettype none

module object_flag_bank #(
	parameter N = 32
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire [N-1:0] set_i,
	input  wire [N-1:0] clr_i,
	output reg  [N-1:0] flags_o
);

	// Set wins over a clear in the same cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			flags_o <= {N{1'b0}};
		end else begin
			flags_o <= (flags_o & ~clr_i) | set_i;
		end
	end

endmodule

`default_nettype wire

// >>> wb_cpu_model.sv
// Classic bus master standing in for the processor
`timescale 1ns/1ps
`default_nettype none

module wb_cpu_model (
	input wire logic		clk_i,
	input wire logic		ack_i,
	output logic			cyc_o,
	output logic			stb_o,
	output logic			we_o,
	output logic	[11:0]	adr_o,
	output logic	[3:0]	sel_o,
	output logic	[31:0]	dat_o
);
	initial begin
		{cyc_o, stb_o, we_o} = 3'h0;
		adr_o = 12'h0;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// Held until acknowledge seen; on release address and data inverted, cycle, strobe, write and selects zeroed
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_o, stb_o, we_o} <= {2'h3, w};
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= d;
		do begin
			@(posedge clk_i);
		end while (ack_i !== 1'b1);
		{cyc_o, stb_o, we_o} <= 3'h0;
		adr_o <= ~a;
		sel_o <= 4'h0;
		dat_o <= ~d;
	endtask
endmodule

`default_nettype wire
